/* File: logic/pfa_pkg.sv */
/*
  Shared constants for the loop-filter, slope-limiter, realignment and
  clock-synthesis control block: register map, field positions, reset values,
  timing counts and synthesizer increments.
  Assumes a single 200 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package pfa_pkg;

  // ********************************************
  // Clock and register map
  // ********************************************
  localparam longint CLK_HZ = 200000000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LIMIT = 8'h08;
  localparam int CTRL_BASE_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_SW_BIT = 2;
  localparam int CTRL_ALIGN_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_ALIGN_BIT = 2;
  localparam int ST_RANGE_BIT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_CLAMP_BIT = 6;

  typedef enum logic [1:0] {
    PFA_F1P5 = 2'b00,
    PFA_F0P1 = 2'b01,
    PFA_F12 = 2'b10,
    PFA_F6 = 2'b11
  } pfa_filter_e;

  typedef enum logic [1:0] {
    PFA_IDLE = 2'b00,
    PFA_HOLD = 2'b01,
    PFA_RELOCK = 2'b10
  } pfa_state_e;

  // ********************************************
  // Timing
  // ********************************************
  localparam longint NS_PER_S = 1000000000;
  localparam longint HOLD_NS = 200;
  localparam longint HOLD_CYC = (HOLD_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint LOCK_DROP_S = 5;
  localparam longint LOCK_LOW_S = 10;
  localparam longint LOCK_DROP_CYC = LOCK_DROP_S * CLK_HZ;
  localparam longint LOCK_LOW_CYC = LOCK_LOW_S * CLK_HZ;
  localparam longint FRAME_US = 125;
  localparam longint FRAME_CYC = FRAME_US * CLK_HZ / 1000000;
  localparam longint FP_WIDE_NS = 244;
  localparam longint FP_MID_NS = 122;
  localparam longint FP_NARROW_NS = 61;
  localparam longint FP_WIDE_CYC = (FP_WIDE_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint FP_MID_CYC = (FP_MID_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam longint FP_NARROW_CYC = (FP_NARROW_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;

  // ********************************************
  // Slope limits, picoseconds per 125 us error sample, and pull range in ppm
  // ********************************************
  localparam int ERR_W = 24;
  localparam longint SAMPLE_US = 125;
  localparam longint SLOPE_1P5_PS = 41000;
  localparam longint SLOPE_6_PS = 50000;
  localparam longint SLOPE_WIN_NS = 1326;
  localparam longint SLOPE_0P1_PS = 885000;
  localparam longint RLN_0P1_PPB = 727;
  localparam longint RLN_FAST_PPB = 31000;
  localparam logic [ERR_W-2:0] LIM_1P5 = (ERR_W-1)'(SLOPE_1P5_PS * SAMPLE_US / SLOPE_WIN_NS);
  localparam logic [ERR_W-2:0] LIM_6 = (ERR_W-1)'(SLOPE_6_PS * SAMPLE_US / SLOPE_WIN_NS);
  localparam logic [ERR_W-2:0] LIM_0P1 = (ERR_W-1)'(SLOPE_0P1_PS * SAMPLE_US / 1000000);
  localparam logic [ERR_W-2:0] LIM_RLN_0P1 = (ERR_W-1)'(RLN_0P1_PPB * SAMPLE_US / 1000);
  localparam logic [ERR_W-2:0] LIM_RLN_FAST = (ERR_W-1)'(RLN_FAST_PPB * SAMPLE_US / 1000);
  localparam logic [ERR_W-2:0] LIM_NONE = '1;
  localparam logic [7:0] PULL_PPM = 8'h14;

  // ********************************************
  // Synthesizer clocks
  // ********************************************
  localparam int NCLK = 12;
  localparam int CK_34 = 9;
  localparam int CK_44 = 10;
  localparam int CK_OPT = 11;
  localparam longint FREQ_HZ [NCLK] = '{1544000, 2048000, 4096000, 6312000, 8192000,
                                       8592000, 11184000, 16384000, 19440000,
                                       34368000, 44736000, 155520000};

  function automatic logic [31:0] nco_inc(input longint f_hz);
    nco_inc = 32'((f_hz << 32) / CLK_HZ);
  endfunction : nco_inc

endpackage : pfa_pkg

/* File: logic/pfa_nco.sv */
/*
  Phase-accumulator clock generator: one square wave at a fixed increment.
  Assumes a synchronous clear from the parent to align the phase.
*/
`timescale 1ns/1ps
module pfa_nco
  import pfa_pkg::*;
#(
  parameter logic [31:0] INC = 32'h0000_0001
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  output logic clk_out
);

  logic [31:0] acc_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 32'h0000_0000;
    end else if (clr) begin
      acc_r <= 32'h0000_0000;
    end else begin
      acc_r <= acc_r + INC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= acc_r[31];
    end
  end

endmodule : pfa_nco

/* File: logic/pfa_ctrl.sv */
/*
  Loop-filter selection, phase-slope limiter, realignment sequencer, lock
  indication and clock/frame synthesis control, with an AHB-Lite register slave.
  Assumes pins are asynchronous and the core-loop signals share hclk.
*/
`timescale 1ns/1ps
module pfa_ctrl
  import pfa_pkg::*;
#(
  parameter logic [31:0] LOCK_DROP = 32'(LOCK_DROP_CYC),
  parameter logic [31:0] LOCK_LOW = 32'(LOCK_LOW_CYC),
  parameter logic [15:0] FRAME_LEN = 16'(FRAME_CYC)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic filter_select_base,
  input wire logic phase_realign_n,
  input wire logic high_rate_output_select,
  input wire logic pdh_line_rate_select,
  input wire logic pll_locked,
  input wire logic holdover_req,
  input wire logic ref_switch,
  input wire logic [7:0] ref_offset_ppm,
  input wire logic [ERR_W-1:0] phase_err,
  input wire logic phase_err_valid,
  output logic [ERR_W-1:0] osc_err,
  output logic osc_err_valid,
  output logic phase_null,
  output logic holdover,
  output logic lock,
  output logic [NCLK-1:0] synth_clk,
  output logic optical_rate_clock,
  output logic pdh_line_clock,
  output logic frame_pulse_wide_low,
  output logic frame_pulse_mid_high,
  output logic frame_pulse_narrow_low
);

  localparam int HOLD_LEN = int'(HOLD_CYC);
  localparam int HOLD_AFTER = int'(HOLD_CYC) + 1;

  // ************************************************
  // Pin synchronizers
  // ************************************************
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  assign pin_raw = {pdh_line_rate_select, high_rate_output_select, phase_realign_n,
                    filter_select_base};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_s1_r[gi] <= 1'b1;
          pin_s2_r[gi] <= 1'b1;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  // ************************************************
  // AHB-Lite register slave
  // ************************************************
  logic [3:0] ctrl_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] status_w;
  logic [ERR_W-2:0] lim_r;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_pend_r && addr_r == OFS_CTRL) begin
      ctrl_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      unique case (haddr[7:0])
        OFS_CTRL: hrdata <= {28'h0000_000, ctrl_r};
        OFS_STATUS: hrdata <= status_w;
        OFS_LIMIT: hrdata <= {{(33 - ERR_W){1'b0}}, lim_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************
  // Filter selection and slope limit
  // ************************************************
  pfa_filter_e mode;
  pfa_state_e st_r;
  logic sw_mode;
  assign sw_mode = ctrl_r[CTRL_SW_BIT];

  always_comb begin
    if (sw_mode) begin
      mode = pfa_filter_e'({ctrl_r[CTRL_EXT_BIT], ctrl_r[CTRL_BASE_BIT]});
    end else begin
      mode = pfa_filter_e'({1'b0, pin_s2_r[0]});
    end
  end

  function automatic logic [ERR_W-2:0] slope_lim(input pfa_filter_e m, input logic rln);
    unique case (m)
      PFA_F1P5: slope_lim = rln ? LIM_RLN_FAST : LIM_1P5;
      PFA_F0P1: slope_lim = rln ? LIM_RLN_0P1 : LIM_0P1;
      PFA_F6: slope_lim = rln ? LIM_RLN_FAST : LIM_6;
      PFA_F12: slope_lim = LIM_NONE;
    endcase
  endfunction : slope_lim

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lim_r <= LIM_1P5;
    end else begin
      lim_r <= slope_lim(mode, st_r != PFA_IDLE);
    end
  end

  logic err_neg;
  logic [ERR_W-1:0] err_mag;
  logic clamp_hit;
  assign err_neg = phase_err[ERR_W-1];
  assign err_mag = err_neg ? ERR_W'(-phase_err) : phase_err;
  assign clamp_hit = err_mag > {1'b0, lim_r};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_err <= '0;
      osc_err_valid <= 1'b0;
    end else begin
      osc_err_valid <= phase_err_valid;
      if (phase_err_valid) begin
        if (!clamp_hit) begin
          osc_err <= phase_err;
        end else if (err_neg) begin
          osc_err <= ERR_W'(-{1'b0, lim_r});
        end else begin
          osc_err <= {1'b0, lim_r};
        end
      end
    end
  end

  // ************************************************
  // Realignment sequencer
  // ************************************************
  logic align_n;
  logic align_n_r;
  logic start;
  logic [31:0] tmr_r;
  logic slow_r;
  logic hold_req_r;
  logic in_range;
  logic lock_drop;
  logic hold_done;

  assign align_n = pin_s2_r[1] && !ctrl_r[CTRL_ALIGN_BIT];
  assign start = align_n_r && !align_n && lock && st_r == PFA_IDLE;
  assign hold_done = st_r == PFA_HOLD && tmr_r == 32'(HOLD_LEN - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      align_n_r <= 1'b1;
      hold_req_r <= 1'b0;
    end else begin
      align_n_r <= align_n;
      hold_req_r <= holdover_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= PFA_IDLE;
      tmr_r <= 32'h0000_0000;
    end else begin
      unique case (st_r)
        PFA_IDLE: begin
          tmr_r <= 32'h0000_0000;
          if (start) begin
            st_r <= PFA_HOLD;
          end
        end
        PFA_HOLD: begin
          if (hold_done) begin
            st_r <= PFA_RELOCK;
            tmr_r <= 32'h0000_0000;
          end else begin
            tmr_r <= tmr_r + 32'h0000_0001;
          end
        end
        PFA_RELOCK: begin
          if (tmr_r == LOCK_DROP + LOCK_LOW - 32'h0000_0001) begin
            st_r <= PFA_IDLE;
          end else begin
            tmr_r <= tmr_r + 32'h0000_0001;
          end
        end
        default: st_r <= PFA_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_r <= 1'b0;
    end else if (start) begin
      slow_r <= !mode[1];
    end
  end

  assign lock_drop = slow_r && st_r == PFA_RELOCK && tmr_r >= LOCK_DROP;
  assign in_range = ref_offset_ppm[7] ? (8'(-ref_offset_ppm) <= PULL_PPM)
                                      : (ref_offset_ppm <= PULL_PPM);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock <= 1'b0;
      holdover <= 1'b0;
      phase_null <= 1'b0;
    end else begin
      lock <= pll_locked && in_range && !lock_drop;
      holdover <= holdover_req || start || (st_r == PFA_HOLD && !hold_done);
      phase_null <= ref_switch || (hold_req_r && !holdover_req) || hold_done;
    end
  end

  assign status_w = {25'h000_0000, clamp_hit, mode, in_range, st_r != PFA_IDLE,
                     holdover, lock};

  // ************************************************
  // Clock synthesizer and frame pulses
  // ************************************************
  generate
    for (gi = 0; gi < NCLK; gi++) begin : g_nco
      pfa_nco #(.INC(nco_inc(FREQ_HZ[gi]))) u_nco (
        .hclk(hclk),
        .hresetn(hresetn),
        .clr(phase_null),
        .clk_out(synth_clk[gi])
      );
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      optical_rate_clock <= 1'b0;
      pdh_line_clock <= 1'b0;
    end else begin
      optical_rate_clock <= !pin_s2_r[2] && synth_clk[CK_OPT];
      if (pin_s2_r[2]) begin
        pdh_line_clock <= pin_s2_r[3] ? synth_clk[CK_44] : synth_clk[CK_34];
      end else begin
        pdh_line_clock <= 1'b0;
      end
    end
  end

  logic [15:0] fcnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt_r <= 16'h0000;
    end else if (phase_null || fcnt_r == FRAME_LEN - 16'h0001) begin
      fcnt_r <= 16'h0000;
    end else begin
      fcnt_r <= fcnt_r + 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_pulse_wide_low <= 1'b1;
      frame_pulse_mid_high <= 1'b0;
      frame_pulse_narrow_low <= 1'b1;
    end else begin
      frame_pulse_wide_low <= !(fcnt_r < 16'(FP_WIDE_CYC));
      frame_pulse_mid_high <= fcnt_r < 16'(FP_MID_CYC);
      frame_pulse_narrow_low <= !(fcnt_r < 16'(FP_NARROW_CYC));
    end
  end

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_hold_enter: assert property (start |=> (st_r == PFA_HOLD && holdover)[*8])
    else $error("realign did not enter holdover");
  chk_hold_exit: assert property (start |-> ##HOLD_AFTER (st_r == PFA_RELOCK && phase_null))
    else $error("holdover phase not 200 ns");
  chk_hw_filter: assert property (!sw_mode |-> (mode[1] == 1'b0 && mode[0] == pin_s2_r[0]))
    else $error("hardware filter select wrong");
  chk_clamp_bound: assert property (phase_err_valid && clamp_hit |=>
      osc_err == ($past(err_neg) ? ERR_W'(-{1'b0, $past(lim_r)}) : {1'b0, $past(lim_r)}))
    else $error("clamped error wrong");
  chk_clamp_pass: assert property (phase_err_valid && !clamp_hit |=> osc_err == $past(phase_err))
    else $error("small error altered");
  chk_lim_mode: assert property (st_r == PFA_IDLE && mode == PFA_F0P1 |=> lim_r == LIM_0P1)
    else $error("0.1 Hz limit wrong");
  chk_lim_rln: assert property (st_r == PFA_RELOCK && mode == PFA_F6 |=> lim_r == LIM_RLN_FAST)
    else $error("realign limit wrong");
  chk_fast_lock: assert property (st_r != PFA_IDLE && !slow_r && pll_locked && in_range |=> lock)
    else $error("lock dropped in fast mode");
  chk_slow_drop: assert property (slow_r && st_r == PFA_RELOCK && tmr_r == LOCK_DROP |=> !lock)
    else $error("lock not dropped at 5 s");
  chk_range_lock: assert property (!in_range |=> !lock)
    else $error("lock outside pull range");
  chk_null_switch: assert property (ref_switch |=> phase_null)
    else $error("no phase null on switch");
  chk_opt_off: assert property (pin_s2_r[2] |=> !optical_rate_clock)
    else $error("optical clock not disabled");
  chk_pdh_pick: assert property (pin_s2_r[2] |=>
      pdh_line_clock == ($past(pin_s2_r[3]) ? $past(synth_clk[CK_44])
                                            : $past(synth_clk[CK_34])))
    else $error("line clock source wrong");
  chk_frame_start: assert property (fcnt_r == 16'h0000 |=>
      (!frame_pulse_wide_low && frame_pulse_mid_high && !frame_pulse_narrow_low))
    else $error("frame pulses not active at frame start");

  cov_realign: cover property (start ##1 st_r == PFA_HOLD);
  cov_slow_drop: cover property (lock_drop && st_r == PFA_RELOCK);
  cov_clamp: cover property (phase_err_valid && clamp_hit);
  cov_frame: cover property (fcnt_r == FRAME_LEN - 16'h0001 ##1 fcnt_r == 16'h0000);

endmodule : pfa_ctrl

/* File: bench/pfa_partner.sv */
/*
  Control-processor model that drives the filter, realign and rate pins.
  Assumes its tasks are called from the bench and that lock comes from the block.
*/
`timescale 1ns/1ps
module pfa_partner (
  input wire logic hclk,
  input wire logic lock,
  output logic filter_select_base,
  output logic phase_realign_n,
  output logic high_rate_output_select,
  output logic pdh_line_rate_select,
  output logic timed_out
);
  initial begin
    filter_select_base = 1'b0;
    phase_realign_n = 1'b1;
    high_rate_output_select = 1'b1;
    pdh_line_rate_select = 1'b0;
    timed_out = 1'b0;
  end

  task automatic wait_lock(input logic lvl);
    int n;
    n = 0;
    while (lock !== lvl && n < 3000) begin
      @(negedge hclk);
      n++;
    end
    if (n >= 3000) timed_out = 1'b1;
  endtask : wait_lock

  task automatic set_pins(input logic b, input logic hr, input logic pl);
    @(posedge hclk);
    filter_select_base <= b;
    high_rate_output_select <= hr;
    pdh_line_rate_select <= pl;
    repeat (5) @(posedge hclk);
  endtask : set_pins

  // The hold is a scaled stand-in for the long documented low times.
  task automatic realign(input int hold, input bit need_lock);
    if (need_lock) wait_lock(1'b1);
    @(posedge hclk);
    phase_realign_n <= 1'b0;
    repeat (hold) @(posedge hclk);
    phase_realign_n <= 1'b1;
  endtask : realign

  task automatic slow_realign(input int hold);
    @(posedge hclk);
    filter_select_base <= 1'b0;
    repeat (4) @(posedge hclk);
    realign(hold, 1'b1);
    wait_lock(1'b0);
    wait_lock(1'b1);
    @(posedge hclk);
    filter_select_base <= 1'b1;
    repeat (4) @(posedge hclk);
  endtask : slow_realign
endmodule : pfa_partner

/* File: bench/test_pll_filter_align_control.sv */
/*
  Self-checking bench for the loop-filter and realignment control block.
  Assumes shortened lock and frame counts, a zero-wait slave and the partner model.
*/
`timescale 1ns/1ps
module test_pll_filter_align_control;
  import pfa_pkg::*;
  localparam int LD = 200;
  localparam int LL = 400;
  localparam int FL = 200;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, hready;
  logic filter_select_base, phase_realign_n, high_rate_output_select;
  logic pdh_line_rate_select, timed_out;
  logic pll_locked = 1'b1, holdover_req = 1'b0, ref_switch = 1'b0;
  logic phase_err_valid = 1'b0;
  logic [7:0] ref_offset_ppm = 8'h00;
  logic [ERR_W-1:0] phase_err = '0, osc_err, got;
  logic osc_err_valid, phase_null, holdover, lock, optical_rate_clock, pdh_line_clock;
  logic frame_pulse_wide_low, frame_pulse_mid_high, frame_pulse_narrow_low;
  logic [NCLK-1:0] synth_clk;
  logic [31:0] lim [4] = '{32'(41000 * 125 / 1326), 32'(885000 * 125 / 1000000),
                           32'h007F_FFFF, 32'(50000 * 125 / 1326)};
  logic [7:0] offs [5] = '{8'h14, 8'h15, 8'hEC, 8'hEB, 8'h00};
  logic lk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  int errors = 0, comparisons = 0, n, r, h, x;
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  pfa_ctrl #(.LOCK_DROP(32'(LD)), .LOCK_LOW(32'(LL)), .FRAME_LEN(16'(FL))) uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .filter_select_base, .phase_realign_n, .high_rate_output_select,
    .pdh_line_rate_select, .pll_locked, .holdover_req, .ref_switch, .ref_offset_ppm,
    .phase_err, .phase_err_valid, .osc_err, .osc_err_valid, .phase_null, .holdover, .lock,
    .synth_clk, .optical_rate_clock, .pdh_line_clock, .frame_pulse_wide_low,
    .frame_pulse_mid_high, .frame_pulse_narrow_low);

  pfa_partner u_ctl (.hclk, .lock, .filter_select_base, .phase_realign_n,
    .high_rate_output_select, .pdh_line_rate_select, .timed_out);

  // ********************************************
  // Checks and bus access
  // ********************************************
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] val);
    comparisons++;
    if (val !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, val);
    end
  endtask : chk

  task automatic chk_rng(input string what, input int lo, input int hi, input int val);
    comparisons++;
    if (val < lo || val > hi) begin
      errors++;
      $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, val);
    end
  endtask : chk_rng

  task automatic hang(input string what);
    errors++;
    $display("wrong value %s expected done seen timeout", what);
    tally_and_finish();
  endtask : hang

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int k;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    chk("resp", 32'h0, 32'(hresp));
    if (k >= 100) hang("bus");
  endtask : ahb

  task automatic clamp(input int e);
    int k;
    @(posedge hclk);
    phase_err <= ERR_W'(e);
    phase_err_valid <= 1'b1;
    @(posedge hclk);
    phase_err_valid <= 1'b0;
    k = 0;
    do begin @(negedge hclk); k++; end while (osc_err_valid !== 1'b1 && k < 10);
    got = osc_err;
    if (k >= 10) hang("clamp");
  endtask : clamp

  // ********************************************
  // Output monitors
  // ********************************************
  function automatic logic pick(input int k);
    case (k)
      0: pick = holdover;
      1: pick = lock;
      2: pick = frame_pulse_wide_low;
      3: pick = frame_pulse_mid_high;
      4: pick = frame_pulse_narrow_low;
      5: pick = pdh_line_clock;
      6: pick = optical_rate_clock;
      7: pick = synth_clk[0];
      9: pick = synth_clk[8];
      default: pick = phase_null;
    endcase
  endfunction : pick

  // Measures the next complete run of the given level.
  task automatic run_len(input int k, input logic lvl, output int len);
    int t;
    t = 0;
    len = 0;
    while (pick(k) === lvl && t < 3000) begin @(negedge hclk); t++; end
    while (pick(k) !== lvl && t < 3000) begin @(negedge hclk); t++; end
    while (pick(k) === lvl && t < 3000) begin @(negedge hclk); t++; len++; end
    if (t >= 3000) hang("run");
  endtask : run_len

  task automatic count(input int k, input int cyc, output int rises, output int highs);
    logic p;
    p = pick(k);
    rises = 0;
    highs = 0;
    repeat (cyc) begin
      @(negedge hclk);
      if (pick(k) === 1'b1 && p === 1'b0) rises++;
      if (pick(k) === 1'b1) highs++;
      p = pick(k);
    end
  endtask : count

  // ********************************************
  // Scenarios
  // ********************************************
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h9, rd);
    ahb(1'b0, 32'h0000_000C, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, OFS_CTRL, 32'hFFFF_FFF4);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h4, rd);
    for (int m = 0; m < 4; m++) begin
      ahb(1'b1, OFS_CTRL, 32'(4 + m));
      ahb(1'b0, OFS_STATUS, 32'h0);
      chk("mode", 32'(m), (rd >> 4) & 32'h3);
      ahb(1'b0, OFS_LIMIT, 32'h0);
      chk("limit", lim[m], rd);
      x = (lim[m] < 32'd5000) ? int'(lim[m]) : 5000;
      clamp(5000);
      chk("clamp", 32'(ERR_W'(x)), 32'(got));
      clamp(-5000);
      chk("clamp", {8'h00, ERR_W'(-x)}, 32'(got));
    end
    foreach (offs[i]) begin
      @(posedge hclk);
      ref_offset_ppm <= offs[i];
      repeat (4) @(negedge hclk);
      chk("lock", 32'(lk[i]), 32'(lock));
    end
    @(posedge hclk);
    ref_switch <= 1'b1;
    @(posedge hclk);
    ref_switch <= 1'b0;
    count(8, 5, r, h);
    chk_rng("null", 1, 1, h);
    @(posedge hclk);
    holdover_req <= 1'b1;
    repeat (3) @(posedge hclk);
    holdover_req <= 1'b0;
    count(8, 5, r, h);
    chk_rng("null", 1, 1, h);
    ahb(1'b1, OFS_CTRL, 32'h7);
    fork
      u_ctl.realign(20, 1'b1);
      run_len(0, 1'b1, n);
      count(8, 80, r, h);
    join
    chk_rng("holdover", 40, 41, n);
    chk_rng("null", 1, 1, r);
    ahb(1'b0, OFS_LIMIT, 32'h0);
    chk("rlimit", 32'(31000 * 125 / 1000), rd);
    count(1, LD + LL, r, h);
    chk_rng("lock", LD + LL, LD + LL, h);
    ahb(1'b1, OFS_CTRL, 32'h5);
    fork
      u_ctl.realign(20, 1'b1);
      run_len(0, 1'b1, n);
    join
    ahb(1'b0, OFS_LIMIT, 32'h0);
    chk("rlimit", 32'(727 * 125 / 1000), rd);
    count(1, LD - 20, r, h);
    chk_rng("lock", LD - 20, LD - 20, h);
    run_len(1, 1'b0, n);
    chk_rng("lock low", LL - 4, LL + 2, n);
    @(posedge hclk);
    pll_locked <= 1'b0;
    fork
      u_ctl.realign(20, 1'b0);
      count(0, 40, r, h);
    join
    chk_rng("refused", 0, 0, h);
    @(posedge hclk);
    pll_locked <= 1'b1;
    ahb(1'b1, OFS_CTRL, 32'hF);
    count(0, 60, r, h);
    chk_rng("sw realign", 40, 41, h);
    ahb(1'b1, OFS_CTRL, 32'h0);
    repeat (LD + LL) @(posedge hclk);
    u_ctl.set_pins(1'b1, 1'b1, 1'b0);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("mode", 32'h1, (rd >> 4) & 32'h3);
    u_ctl.slow_realign(20);
    chk("partner", 32'h0, 32'(timed_out));
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h11, rd & 32'h31);
    u_ctl.set_pins(1'b0, 1'b1, 1'b0);
    count(5, 2000, r, h);
    chk_rng("line clk", 342, 345, r);
    count(6, 2000, r, h);
    chk_rng("optical", 0, 0, r);
    count(7, 2000, r, h);
    chk_rng("synth", 14, 17, r);
    chk_rng("synth duty", 930, 1070, h);
    count(9, 2000, r, h);
    chk_rng("synth", 193, 196, r);
    u_ctl.set_pins(1'b0, 1'b1, 1'b1);
    count(5, 2000, r, h);
    chk_rng("line clk", 446, 449, r);
    u_ctl.set_pins(1'b0, 1'b0, 1'b0);
    count(6, 2000, r, h);
    chk_rng("optical", 1, 2000, r);
    run_len(2, 1'b0, n);
    chk_rng("wide", 49, 49, n);
    run_len(2, 1'b1, n);
    chk_rng("frame", FL - 49, FL - 49, n);
    run_len(3, 1'b1, n);
    chk_rng("mid", 25, 25, n);
    run_len(4, 1'b0, n);
    chk_rng("narrow", 13, 13, n);
    tally_and_finish();
  end
endmodule : test_pll_filter_align_control
